//--- tss_regs.svh
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH
// ----------------------------------------
// bus codes
// ----------------------------------------
`define TSS_ADDR_BASE 4'h9
`define TSS_GC_BYTE 8'h00
`define TSS_GC_LATCH 8'h04
`define TSS_GC_RESET 8'h06
`define TSS_ALERT_CMD 8'h19
`define TSS_HS_CODE 5'h01
`define TSS_PTR_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define TSS_CLK_MHZ 125
`define TSS_CLK_NS 8
`define TSS_TIMEOUT_MS 54
`define TSS_TIMEOUT_CYC (`TSS_TIMEOUT_MS * 1000 * `TSS_CLK_MHZ)
`define TSS_LINK_PERIOD_NS 160
`define TSS_QTR_CYC ((`TSS_LINK_PERIOD_NS / `TSS_CLK_NS) / 4)
// ----------------------------------------
// controller registers
// ----------------------------------------
`define TSS_CTRL_OFS 12'h000
`define TSS_TX_OFS 12'h004
`define TSS_RX_OFS 12'h008
`define TSS_STAT_OFS 12'h00C
`define TSS_DIV_OFS 12'h010
`define TSS_CTRL_GO 0
`define TSS_CTRL_CMD_LSB 1
`define TSS_CTRL_NACK 3
`define TSS_STAT_BUSY 0
`define TSS_STAT_ACK 1
`define TSS_STAT_SCL 2
`define TSS_STAT_SDA 3
`endif

//--- tss_pkg.sv
package tss_pkg;
   typedef enum logic [4:0] {
      D_IDLE = 5'h01,
      D_RX = 5'h02,
      D_ACK = 5'h04,
      D_TX = 5'h08,
      D_MACK = 5'h10
   } tss_dev_state_t;
   typedef enum logic [2:0] {
      K_PTR = 3'h0,
      K_DATA = 3'h1,
      K_GC = 3'h2,
      K_READ = 3'h3,
      K_ALERT = 3'h4
   } tss_role_t;
   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_START = 4'h2,
      H_STOP = 4'h4,
      H_XFER = 4'h8
   } tss_host_state_t;
   typedef enum logic [1:0] {
      C_START = 2'h0,
      C_STOP = 2'h1,
      C_WRITE = 2'h2,
      C_READ = 2'h3
   } tss_cmd_t;
endpackage

//--- tss_if.sv
`timescale 1ns/1ps
interface tss_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // open-drain wired-and: scl from the host alone, sda of both ends
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface

//--- tss_dev.sv
`timescale 1ns/1ps
`include "tss_regs.svh"
// Summary of operation
// - read sends pointed register, MSB byte first
// - master acks bytes; nack/start/stop ends read
// - alert response acked, own address returned
// - address LSB flags high or low limit
// - arbitrate address bits; winner clears alert
// - ack general call write, next byte command
// - general call 04 relatches address pins
// - general call 06 relatches and resets registers
// - hs master code not acked, hs on
// - hs mode held until stop
// - master sends hs code before fast clocks
// - line low 54ms resets serial interface
// - master keeps scl at 1kHz or faster
// - start/stop are sda edges while scl high
// - no limit on bytes per transfer
// - receiver holds sda low over ack clock
// - repeated start ends transfer, new address
// - all bytes shift most significant bit first
// - pointer kept until next write supplies one or general call 06 clears it
// - address pins latched at reset, start, request
module tss_dev #(
   parameter int TIMEOUT_CYC = `TSS_TIMEOUT_CYC
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   tss_if.dev lnk, // two-wire link
   input wire logic [15:0] reg_rdata, // register chosen by ptr
   input wire logic interrupt_mode_select, // interrupt mode
   input wire logic alert_active, // alert output active
   input wire logic alert_above_high, // alert cause: at/above upper limit
   input wire logic addr_select_pin_0, // address select pin
   input wire logic addr_select_pin_1, // address select pin
   input wire logic addr_select_pin_2, // address select pin
   output logic [7:0] ptr, // register pointer
   output logic wr_valid, // write data byte pulse
   output logic [7:0] wr_data, // write data byte
   output logic reg_reset, // register reset pulse
   output logic alert_clear, // alert clear pulse
   output logic hs_mode, // high-speed filters selected
   output logic [6:0] slave_addr // latched slave address
);
   // ----------------------------------------
   // synchronisers and bus events
   // ----------------------------------------
   logic [2:0] scl_sh_reg;
   logic [2:0] sda_sh_reg;
   logic [2:0] pin_s1_reg;
   logic [2:0] pin_s2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sh_reg <= 3'h7;
         sda_sh_reg <= 3'h7;
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
      end else begin
         scl_sh_reg <= {scl_sh_reg[1:0], lnk.scl};
         sda_sh_reg <= {sda_sh_reg[1:0], lnk.sda};
         pin_s1_reg <= {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   wire scl_now = scl_sh_reg[1];
   wire sda_now = sda_sh_reg[1];
   wire scl_rise = scl_now & ~scl_sh_reg[2];
   wire scl_fall = ~scl_now & scl_sh_reg[2];
   wire scl_both = scl_now & scl_sh_reg[2];
   wire start_det = scl_both & sda_sh_reg[2] & ~sda_now;
   wire stop_det = scl_both & ~sda_sh_reg[2] & sda_now;
   wire [6:0] pin_addr = {`TSS_ADDR_BASE, pin_s2_reg};
   // ----------------------------------------
   // state
   // ----------------------------------------
   tss_pkg::tss_dev_state_t state_reg;
   tss_pkg::tss_role_t role_reg;
   logic [7:0] rx_reg;
   logic [7:0] tx_reg;
   logic [3:0] bit_reg;
   logic addr_phase_reg;
   logic first_reg;
   logic hi_reg;
   logic in_xfer_reg;
   logic sda_oe_reg;
   logic sda_o_reg;
   logic [1:0] strap_reg;
   logic [22:0] to_cnt_reg;
   logic [7:0] ptr_reg;
   logic wr_valid_reg;
   logic [7:0] wr_data_reg;
   logic reg_reset_reg;
   logic alert_clear_reg;
   logic hs_mode_reg;
   logic [6:0] addr_reg;
   // ----------------------------------------
   // byte decode
   // ----------------------------------------
   wire byte_done = scl_fall & (bit_reg == 4'h8);
   wire is_hs = first_reg & (rx_reg[7:3] == `TSS_HS_CODE);
   wire is_me = rx_reg[7:1] == addr_reg;
   wire is_gc = rx_reg == `TSS_GC_BYTE;
   wire is_ara = (rx_reg == `TSS_ALERT_CMD) & interrupt_mode_select & alert_active;
   wire gc_latch = (rx_reg == `TSS_GC_LATCH) | (rx_reg == `TSS_GC_RESET);
   wire ack_addr = is_me | is_gc | is_ara;
   wire ack_byte = addr_phase_reg ? (ack_addr & ~is_hs) :
                   (role_reg == tss_pkg::K_GC) ? gc_latch : 1'b1;
   wire [7:0] rd_byte = hi_reg ? reg_rdata[15:8] : reg_rdata[7:0];
   wire [7:0] ara_byte = {addr_reg, alert_above_high};
   wire [7:0] load_byte = (role_reg == tss_pkg::K_ALERT) ? ara_byte : rd_byte;
   wire line_low = ~scl_now | ~sda_now;
   wire timeout = to_cnt_reg == 23'(TIMEOUT_CYC - 1);
   wire arb_lost = ~sda_oe_reg & ~sda_now & (role_reg == tss_pkg::K_ALERT);
   // ----------------------------------------
   // timeout counter
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_cnt_reg <= 23'h0;
      end else if (in_xfer_reg & line_low & ~timeout) begin
         to_cnt_reg <= to_cnt_reg + 23'h1;
      end else begin
         to_cnt_reg <= 23'h0;
      end
   end
   // ----------------------------------------
   // address latch and pulses
   // ----------------------------------------
   wire gc_cmd = byte_done & ~addr_phase_reg & (role_reg == tss_pkg::K_GC);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_reg <= 2'h0;
         addr_reg <= 7'h0;
      end else if (strap_reg != 2'h3) begin
         strap_reg <= strap_reg + 2'h1;
         addr_reg <= pin_addr;
      end else if (start_det | (gc_cmd & gc_latch)) begin
         addr_reg <= pin_addr;
      end
   end
   // ----------------------------------------
   // link state machine
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= tss_pkg::D_IDLE;
         role_reg <= tss_pkg::K_PTR;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         bit_reg <= 4'h0;
         addr_phase_reg <= 1'b0;
         first_reg <= 1'b0;
         hi_reg <= 1'b1;
         in_xfer_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         sda_o_reg <= 1'b0;
         ptr_reg <= `TSS_PTR_RST;
         wr_valid_reg <= 1'b0;
         wr_data_reg <= 8'h00;
         reg_reset_reg <= 1'b0;
         alert_clear_reg <= 1'b0;
         hs_mode_reg <= 1'b0;
      end else begin
         wr_valid_reg <= 1'b0;
         reg_reset_reg <= 1'b0;
         alert_clear_reg <= 1'b0;
         if (timeout) begin
            state_reg <= tss_pkg::D_IDLE;
            sda_oe_reg <= 1'b0;
            in_xfer_reg <= 1'b0;
         end else if (stop_det) begin
            state_reg <= tss_pkg::D_IDLE;
            sda_oe_reg <= 1'b0;
            in_xfer_reg <= 1'b0;
            hs_mode_reg <= 1'b0;
         end else if (start_det) begin
            state_reg <= tss_pkg::D_RX;
            sda_oe_reg <= 1'b0;
            bit_reg <= 4'h0;
            addr_phase_reg <= 1'b1;
            first_reg <= ~in_xfer_reg | ~hs_mode_reg;
            in_xfer_reg <= 1'b1;
         end else begin
            case (state_reg)
               tss_pkg::D_RX: begin
                  if (scl_rise) begin
                     rx_reg <= {rx_reg[6:0], sda_now};
                     bit_reg <= bit_reg + 4'h1;
                  end else if (byte_done) begin
                     bit_reg <= 4'h0;
                     first_reg <= 1'b0;
                     sda_oe_reg <= ack_byte;
                     state_reg <= ack_byte ? tss_pkg::D_ACK : tss_pkg::D_IDLE;
                     if (addr_phase_reg) begin
                        if (is_hs) begin
                           hs_mode_reg <= 1'b1;
                        end else if (is_me) begin
                           role_reg <= rx_reg[0] ? tss_pkg::K_READ : tss_pkg::K_PTR;
                           hi_reg <= 1'b1;
                        end else if (is_gc) begin
                           role_reg <= tss_pkg::K_GC;
                        end else begin
                           role_reg <= tss_pkg::K_ALERT;
                        end
                     end else if (role_reg == tss_pkg::K_PTR) begin
                        ptr_reg <= rx_reg;
                        role_reg <= tss_pkg::K_DATA;
                     end else if (role_reg == tss_pkg::K_DATA) begin
                        wr_valid_reg <= 1'b1;
                        wr_data_reg <= rx_reg;
                     end else begin
                        reg_reset_reg <= rx_reg == `TSS_GC_RESET;
                        if (rx_reg == `TSS_GC_RESET) begin
                           ptr_reg <= `TSS_PTR_RST;
                        end
                     end
                  end
               end
               tss_pkg::D_ACK: begin
                  if (scl_fall) begin
                     addr_phase_reg <= 1'b0;
                     if ((role_reg == tss_pkg::K_READ) | (role_reg == tss_pkg::K_ALERT)) begin
                        state_reg <= tss_pkg::D_TX;
                        tx_reg <= load_byte;
                        sda_oe_reg <= ~load_byte[7];
                        hi_reg <= ~hi_reg;
                     end else begin
                        state_reg <= tss_pkg::D_RX;
                        sda_oe_reg <= 1'b0;
                     end
                  end
               end
               tss_pkg::D_TX: begin
                  if (scl_rise) begin
                     bit_reg <= bit_reg + 4'h1;
                     if (arb_lost) begin
                        state_reg <= tss_pkg::D_IDLE;
                     end
                  end else if (scl_fall) begin
                     if (bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        sda_oe_reg <= 1'b0;
                        state_reg <= tss_pkg::D_MACK;
                     end else begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe_reg <= ~tx_reg[6];
                     end
                  end
               end
               tss_pkg::D_MACK: begin
                  if (scl_rise) begin
                     if (role_reg == tss_pkg::K_ALERT) begin
                        alert_clear_reg <= 1'b1;
                        state_reg <= tss_pkg::D_IDLE;
                     end else if (sda_now) begin
                        state_reg <= tss_pkg::D_IDLE;
                     end else begin
                        state_reg <= tss_pkg::D_ACK;
                     end
                  end
               end
               default: begin
                  sda_oe_reg <= 1'b0;
               end
            endcase
         end
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign lnk.dev_sda_o = sda_o_reg;
   assign lnk.dev_sda_oe = sda_oe_reg;
   assign ptr = ptr_reg;
   assign wr_valid = wr_valid_reg;
   assign wr_data = wr_data_reg;
   assign reg_reset = reg_reset_reg;
   assign alert_clear = alert_clear_reg;
   assign hs_mode = hs_mode_reg;
   assign slave_addr = addr_reg;
endmodule

//--- tss_host.sv
`timescale 1ns/1ps
`include "tss_regs.svh"
module tss_host (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   tss_if.host lnk // two-wire link
);
   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic [15:0] div_reg;
   logic ack_reg;
   logic nack_reg;
   tss_pkg::tss_cmd_t cmd_reg;
   tss_pkg::tss_host_state_t state_reg;
   logic [1:0] scl_s_reg;
   logic [1:0] sda_s_reg;
   wire busy = state_reg != tss_pkg::H_IDLE;
   wire sel_ctrl = paddr == `TSS_CTRL_OFS;
   wire sel_tx = paddr == `TSS_TX_OFS;
   wire sel_rx = paddr == `TSS_RX_OFS;
   wire sel_stat = paddr == `TSS_STAT_OFS;
   wire sel_div = paddr == `TSS_DIV_OFS;
   wire mapped = sel_ctrl | sel_tx | sel_rx | sel_stat | sel_div;
   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready_reg & pwrite & mapped;
   wire go = wr_en & sel_ctrl & pwdata[`TSS_CTRL_GO] & ~busy;
   wire [31:0] stat_word = {28'h0, sda_s_reg[1], scl_s_reg[1], ack_reg, busy};
   wire [31:0] rd_word = sel_tx ? {24'h0, tx_reg} :
                         sel_rx ? {24'h0, rx_reg} :
                         sel_stat ? stat_word :
                         sel_div ? {16'h0, div_reg} : 32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         prdata_reg <= setup ? rd_word : 32'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_reg <= 8'h00;
         div_reg <= 16'(`TSS_QTR_CYC);
      end else if (wr_en & sel_tx) begin
         tx_reg <= pwdata[7:0];
      end else if (wr_en & sel_div) begin
         div_reg <= pwdata[15:0];
      end
   end
   // ----------------------------------------
   // link engine
   // ----------------------------------------
   logic [15:0] q_cnt_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic scl_oe_reg;
   logic sda_oe_reg;
   logic zero_reg;
   wire tick = (q_cnt_reg + 16'h1) >= div_reg;
   wire last_bit = bit_reg == 4'h8;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s_reg <= 2'h3;
         sda_s_reg <= 2'h3;
         q_cnt_reg <= 16'h0;
      end else begin
         scl_s_reg <= {scl_s_reg[0], lnk.scl};
         sda_s_reg <= {sda_s_reg[0], lnk.sda};
         q_cnt_reg <= (tick | ~busy) ? 16'h0 : q_cnt_reg + 16'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= tss_pkg::H_IDLE;
         cmd_reg <= tss_pkg::C_START;
         nack_reg <= 1'b0;
         phase_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rx_reg <= 8'h00;
         ack_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         zero_reg <= 1'b0;
      end else if (go) begin
         cmd_reg <= tss_pkg::tss_cmd_t'(pwdata[`TSS_CTRL_CMD_LSB +: 2]);
         nack_reg <= pwdata[`TSS_CTRL_NACK];
         phase_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= tx_reg;
         case (tss_pkg::tss_cmd_t'(pwdata[`TSS_CTRL_CMD_LSB +: 2]))
            tss_pkg::C_START: state_reg <= tss_pkg::H_START;
            tss_pkg::C_STOP: state_reg <= tss_pkg::H_STOP;
            default: state_reg <= tss_pkg::H_XFER;
         endcase
      end else if (busy & tick) begin
         phase_reg <= phase_reg + 2'h1;
         case (state_reg)
            tss_pkg::H_START: begin
               // release sda, raise scl, then sda falls while scl high
               if (phase_reg == 2'h0) sda_oe_reg <= 1'b0;
               if (phase_reg == 2'h1) scl_oe_reg <= 1'b0;
               if (phase_reg == 2'h2) sda_oe_reg <= 1'b1;
               if (phase_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  state_reg <= tss_pkg::H_IDLE;
               end
            end
            tss_pkg::H_STOP: begin
               if (phase_reg == 2'h0) sda_oe_reg <= 1'b1;
               if (phase_reg == 2'h1) scl_oe_reg <= 1'b0;
               if (phase_reg == 2'h2) sda_oe_reg <= 1'b0;
               if (phase_reg == 2'h3) state_reg <= tss_pkg::H_IDLE;
            end
            tss_pkg::H_XFER: begin
               if (phase_reg == 2'h0) begin
                  if (cmd_reg == tss_pkg::C_WRITE) begin
                     sda_oe_reg <= ~last_bit & ~sh_reg[7];
                  end else begin
                     sda_oe_reg <= last_bit & ~nack_reg;
                  end
               end
               if (phase_reg == 2'h1) scl_oe_reg <= 1'b0;
               if (phase_reg == 2'h2) begin
                  if (last_bit) begin
                     ack_reg <= ~sda_s_reg[1];
                  end else begin
                     sh_reg <= {sh_reg[6:0], sda_s_reg[1]};
                  end
               end
               if (phase_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  bit_reg <= bit_reg + 4'h1;
                  if (last_bit) begin
                     state_reg <= tss_pkg::H_IDLE;
                     rx_reg <= sh_reg;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            default: state_reg <= tss_pkg::H_IDLE;
         endcase
      end
   end
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign lnk.host_scl_o = zero_reg;
   assign lnk.host_scl_oe = scl_oe_reg;
   assign lnk.host_sda_o = zero_reg;
   assign lnk.host_sda_oe = sda_oe_reg;
endmodule

//--- tss_monitor.sv
`timescale 1ns/1ps
module tss_monitor #(
   parameter int TIMEOUT_CYC = 2000
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   input wire logic host_scl_o, // host scl value
   input wire logic host_scl_oe, // host scl pull
   input wire logic host_sda_o, // host sda value
   input wire logic host_sda_oe, // host sda pull
   input wire logic dev_sda_o, // device sda value
   input wire logic dev_sda_oe, // device sda pull
   input wire logic scl, // scl line
   input wire logic sda // sda line
);
   int scl_low_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_low_cnt <= 0;
      end else begin
         scl_low_cnt <= scl ? 0 : scl_low_cnt + 1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence start_seq;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_seq;
      scl && $past(scl) && $rose(sda);
   endsequence
   a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device sda not open drain");
   a_host_open_drain: assert property (host_sda_oe || host_scl_oe |->
      !(host_sda_oe && host_sda_o) && !(host_scl_oe && host_scl_o))
      else $error("host line not open drain");
   a_dev_steady_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda moved while scl high");
   a_dev_fall_lag: assert property ($fell(scl) |=> $stable(dev_sda_oe))
      else $error("device sda moved too soon after scl fall");
   a_start_quiet: assert property (start_seq |-> !dev_sda_oe [*8])
      else $error("device drives sda after start");
   a_stop_quiet: assert property (stop_seq |-> !dev_sda_oe [*8])
      else $error("device drives sda after stop");
   a_stuck_release: assert property (scl_low_cnt >= TIMEOUT_CYC + 16 |-> !dev_sda_oe)
      else $error("device holds sda past timeout");
   a_scl_high_len: assert property ($rose(scl) |-> scl [*4])
      else $error("scl high phase too short");
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
   localparam int TO = 2000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic interrupt_mode_select, alert_active, alert_above_high, wr_valid;
   logic reg_reset, alert_clear, hs_mode;
   logic [2:0] pins;
   logic [7:0] ptr, wr_data, last_wr;
   logic [6:0] slave_addr;
   logic [15:0] reg_rdata;
   int n_fail, samples_checked, n_clear, n_rst, cyc;
   tss_if lnk();
   assign reg_rdata = {1'b0, ptr[6:0], ~ptr};
   tss_host tss_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lnk(lnk));
   tss_dev #(.TIMEOUT_CYC(TO)) tss_dev_i (.pclk(pclk), .presetn(presetn), .lnk(lnk),
      .reg_rdata(reg_rdata), .interrupt_mode_select(interrupt_mode_select),
      .alert_active(alert_active), .alert_above_high(alert_above_high),
      .addr_select_pin_0(pins[0]), .addr_select_pin_1(pins[1]),
      .addr_select_pin_2(pins[2]), .ptr(ptr), .wr_valid(wr_valid), .wr_data(wr_data),
      .reg_reset(reg_reset), .alert_clear(alert_clear), .hs_mode(hs_mode),
      .slave_addr(slave_addr));
   tss_monitor #(.TIMEOUT_CYC(TO)) tss_monitor_i (.pclk(pclk), .presetn(presetn),
      .host_scl_o(lnk.host_scl_o), .host_scl_oe(lnk.host_scl_oe),
      .host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe),
      .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // pulse capture
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (wr_valid === 1'b1) last_wr <= wr_data;
      if (alert_clear === 1'b1) n_clear <= n_clear + 1;
      if (reg_reset === 1'b1) n_rst <= n_rst + 1;
      if (cyc == 40000) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked = samples_checked + 1;
      if (s !== e) begin
         n_fail = n_fail + 1;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // access ends at the rising edge where pready is seen high
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic xfer(input tss_pkg::tss_cmd_t c, input logic [7:0] tx, input logic nk);
      apb(1'b1, 12'h004, {24'h0, tx});
      apb(1'b1, 12'h000, {28'h0, nk, c, 1'b1});
      do apb(1'b0, 12'h00C, 32'h0); while (rd[0] !== 1'b0);
      ack = rd[1];
   endtask
   task automatic wb(input logic [7:0] b, input logic e);
      xfer(tss_pkg::C_WRITE, b, 1'b0);
      chk("ack", ack, e);
   endtask
   task automatic rb(input logic nk, input logic [7:0] e);
      xfer(tss_pkg::C_READ, 8'h00, nk);
      apb(1'b0, 12'h008, 32'h0);
      chk("rx", rd[7:0], e);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {interrupt_mode_select, alert_active, alert_above_high} = 3'h0;
      pins = 3'h5;
      {n_fail, samples_checked, n_clear, n_rst, cyc} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("addr", slave_addr, 7'h4D);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h9A, 1'b1);
      wb(8'h21, 1'b1);
      wb(8'hC3, 1'b1);
      chk("ptr", ptr, 8'h21);
      chk("wr", last_wr, 8'hC3);
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h9B, 1'b1);
      rb(1'b0, 8'h21);
      rb(1'b1, 8'hDE);
      xfer(tss_pkg::C_STOP, 8'h00, 1'b0);
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h9B, 1'b1);
      rb(1'b1, 8'h21);
      xfer(tss_pkg::C_STOP, 8'h00, 1'b0);
      // alert response refused while interrupt mode is off
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h19, 1'b0);
      interrupt_mode_select <= 1'b1;
      alert_active <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         alert_above_high <= i[0];
         xfer(tss_pkg::C_START, 8'h00, 1'b0);
         wb(8'h19, 1'b1);
         rb(1'b1, {7'h4D, i[0]});
         xfer(tss_pkg::C_STOP, 8'h00, 1'b0);
         chk("clears", n_clear, i + 1);
      end
      // read left hanging with scl low until the interface gives up
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h9B, 1'b1);
      repeat (TO + 200) @(posedge pclk);
      apb(1'b0, 12'h00C, 32'h0);
      chk("sda", rd[3], 1'b1);
      xfer(tss_pkg::C_STOP, 8'h00, 1'b0);
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h09, 1'b0);
      chk("hs", hs_mode, 1'b1);
      xfer(tss_pkg::C_START, 8'h00, 1'b0);
      wb(8'h9A, 1'b1);
      chk("hs", hs_mode, 1'b1);
      xfer(tss_pkg::C_STOP, 8'h00, 1'b0);
      chk("hs", hs_mode, 1'b0);
      for (int i = 0; i < 2; i++) begin
         xfer(tss_pkg::C_START, 8'h00, 1'b0);
         wb(8'h00, 1'b1);
         // pins move after the start so only the command can latch them
         pins <= i ? 3'h7 : 3'h2;
         wb(i ? 8'h06 : 8'h04, 1'b1);
         xfer(tss_pkg::C_STOP, 8'h00, 1'b0);
         chk("addr", slave_addr, i ? 7'h4F : 7'h4A);
         chk("ptr", ptr, i ? 8'h00 : 8'h21);
         chk("resets", n_rst, i);
      end
      print_verdict();
   end
endmodule
